/* hw/fdt_map.vh */
// register map, field positions, encodings and timing for the track encoder
// assumes a 250 MHz controller clock and word-aligned avalon byte addresses
`ifndef FDT_MAP_VH
`define FDT_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define FDT_OFS_CMD_STAT   4'h0
`define FDT_OFS_DATA       4'h4
`define FDT_OFS_CTRL       4'h8

// ------------------------------------------------------------
// command and control register fields
// ------------------------------------------------------------
`define FDT_CMD_FORCE      4'hd
`define FDT_COND_INDEX     2
`define FDT_COND_IMM       3
`define FDT_CTRL_DENS_BIT  0
`define FDT_CTRL_RESET     1'b1

// ------------------------------------------------------------
// status bit positions
// ------------------------------------------------------------
`define FDT_ST_BUSY        0
`define FDT_ST_DRQ         1
`define FDT_ST_LOST        2

// ------------------------------------------------------------
// data pattern decode
// ------------------------------------------------------------
`define FDT_PAT_LAST_PLAIN 8'hf4
`define FDT_PAT_A1_CODE    8'hf5
`define FDT_PAT_C2_CODE    8'hf6
`define FDT_PAT_CRC        8'hf7
`define FDT_PAT_AM_LO      8'hf8
`define FDT_PAT_AM_HI      8'hfb
`define FDT_PAT_FC         8'hfc
`define FDT_PAT_FE         8'hfe
`define FDT_MARK_A1        8'ha1
`define FDT_MARK_C2        8'hc2
`define FDT_CLK_ALL        8'hff
`define FDT_CLK_C7         8'hc7
`define FDT_CLK_D7         8'hd7
`define FDT_CLK_MISS_4_5   8'hef
`define FDT_CLK_MISS_3_4   8'hf7
`define FDT_FILL_BYTE      8'h00

// ------------------------------------------------------------
// crc and timing
// ------------------------------------------------------------
`define FDT_CRC_PRESET     16'hffff
`define FDT_CRC_POLY       16'h1021
`define FDT_CLK_MHZ        14'd250
`define FDT_BYTE_US_FM     14'd32
`define FDT_BYTE_US_MFM    14'd16
`define FDT_START_SLOTS    2'd2

`endif

/* hw/fdt_track_encode.v */
// track-format encoder with forced-interrupt handling and status register
// assumes a synchronous avalon-mm master and a synchronous index pulse input
//
// How it works
// R1 - fm: 00-f4 written with clock ff
// R2 - mfm f5: a1 missing clock, preset crc
// R3 - mfm f6: c2 missing clock 3-4
// R4 - f7 emits two crc bytes
// R5 - fm f8-fb clock c7, preset crc
// R6 - fm fc uses clock d7
// R7 - fm fe c7 preset; fd ff clock ff
// R8 - forced interrupt accepted anytime, clears busy
// R9 - bit2 index interrupt, bit3 immediate interrupt
// R10 - enabled condition drives interrupt output high
// R11 - zero conditions: no interrupt, terminate command
// R12 - immediate interrupt held until d0 loaded
// R13 - host waits 16/32 us after forced interrupt
// R14 - termination waits for crc byte completion
// R15 - new command sets busy, clears status
// R16 - forced while idle refreshes positioning status
// R17 - data register access clears data request
// R18 - status read clears interrupt, except immediate
// R19 - eight-bit status, busy in bit 0
// R20 - host delays before reading status back
// R21 - host keeps non-standard format limits
// R22 - host keeps gap 2 exact
// R23 - empty data register writes zero byte
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
`include "fdt_map.vh"

module fdt_track_encode #(
	parameter [13:0] BYTE_CYC_FM  = `FDT_BYTE_US_FM * `FDT_CLK_MHZ,
	parameter [13:0] BYTE_CYC_MFM = `FDT_BYTE_US_MFM * `FDT_CLK_MHZ
) (
	// clock, reset, enable
	input  wire        clk,
	input  wire        rstn,
	input  wire        ce,
	// avalon-mm slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// drive and host pins
	input  wire        index_pulse,
	output wire        density_select_n,
	output wire        interrupt_request_out,
	output wire        data_request_out,
	// write stream to the drive
	output reg         wr_gate,
	output reg         wr_strobe,
	output reg  [7:0]  wr_byte,
	output reg  [7:0]  wr_clk
);

	// crc-16 over one byte, msb first
	function [15:0] crc_step;
		input [15:0] crc;
		input [7:0]  din;
		integer      i;
		begin
			crc_step = crc;
			for (i = 7; i >= 0; i = i - 1)
				crc_step = {crc_step[14:0], 1'b0} ^ ((crc_step[15] ^ din[i]) ? `FDT_CRC_POLY : 16'h0000);
		end
	endfunction

	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_WAIT = 2'd1;
	localparam [1:0] ST_RUN  = 2'd2;
	localparam [1:0] ST_CRC  = 2'd3;

	reg [1:0]  state_q;
	reg [13:0] cnt_q;
	reg [1:0]  miss_q;
	reg [7:0]  dr_q;
	reg        dr_full_q;
	reg        drq_q;
	reg        busy_q;
	reg        lost_q;
	reg        type1_q;
	reg        interrupt_request_out_q;
	reg        imm_q;
	reg        idx_en_q;
	reg        force_pend_q;
	reg        idx_seen_q;
	reg        idx_prev_q;
	reg        dens_n_q;
	reg [15:0] crc_q;
	reg        ack_q;

	// bus decode
	wire acc      = (avs_read | avs_write) & ~ack_q;
	wire wr_cmd   = ce & ack_q & avs_write & avs_byteenable[0] & (avs_address == `FDT_OFS_CMD_STAT);
	wire rd_stat  = ce & ack_q & avs_read & (avs_address == `FDT_OFS_CMD_STAT);
	wire wr_dr    = ce & ack_q & avs_write & avs_byteenable[0] & (avs_address == `FDT_OFS_DATA);
	wire rd_dr    = ce & ack_q & avs_read & (avs_address == `FDT_OFS_DATA);
	wire wr_ctrl  = ce & ack_q & avs_write & avs_byteenable[0] & (avs_address == `FDT_OFS_CTRL);
	wire [7:0] cmd = avs_writedata[7:0];
	wire is_force  = (cmd[7:4] == `FDT_CMD_FORCE);
	wire force_cmd = wr_cmd & is_force;
	wire new_cmd   = wr_cmd & ~is_force;

	// one wait cycle, so every answer lands at the second edge
	assign avs_waitrequest = acc;

	// status: drq or index level in bit 1 depending on command type
	wire [7:0] status = {5'h00, lost_q & ~type1_q, type1_q ? index_pulse : drq_q, busy_q}; // see R19, R16

	assign density_select_n      = dens_n_q;
	assign interrupt_request_out = interrupt_request_out_q;
	assign data_request_out      = drq_q;

	// byte slot timing
	wire [13:0] byte_cyc = dens_n_q ? BYTE_CYC_FM : BYTE_CYC_MFM;
	wire        tick     = ce & (state_q != ST_IDLE) & (cnt_q == 14'h0000);
	wire        idx_rise = ce & index_pulse & ~idx_prev_q;

	// pattern decode of the byte leaving the data register
	reg  [7:0] enc_byte;
	reg  [7:0] enc_clk;
	reg        enc_preset;
	reg        enc_crc;
	wire [7:0] src = dr_full_q ? dr_q : `FDT_FILL_BYTE; // see R23

	always @*
	begin
		enc_byte   = src;
		enc_clk    = `FDT_CLK_ALL; // see R1
		enc_preset = 1'b0;
		enc_crc    = 1'b0;
		if (src == `FDT_PAT_CRC)
			enc_crc = 1'b1; // see R4
		else if (!dens_n_q)
		begin
			// mfm: only f5 and f6 are special, the rest is plain data
			if (src == `FDT_PAT_A1_CODE)
			begin
				enc_byte   = `FDT_MARK_A1;
				enc_clk    = `FDT_CLK_MISS_4_5;
				enc_preset = 1'b1; // see R2
			end
			else if (src == `FDT_PAT_C2_CODE)
			begin
				enc_byte = `FDT_MARK_C2;
				enc_clk  = `FDT_CLK_MISS_3_4; // see R3
			end
		end
		else if (src >= `FDT_PAT_AM_LO && src <= `FDT_PAT_AM_HI)
		begin
			enc_clk    = `FDT_CLK_C7;
			enc_preset = 1'b1; // see R5
		end
		else if (src == `FDT_PAT_FC)
			enc_clk = `FDT_CLK_D7; // see R6
		else if (src == `FDT_PAT_FE)
		begin
			enc_clk    = `FDT_CLK_C7;
			enc_preset = 1'b1; // see R7
		end
	end

	// the mark itself is folded into the freshly preset crc
	wire [15:0] crc_next = crc_step(enc_preset ? `FDT_CRC_PRESET : crc_q, enc_byte);

	// bus answer register
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h00000000;
		end
		else if (ce)
		begin
			ack_q <= acc;
			if (acc)
			begin
				case (avs_address)
					`FDT_OFS_CMD_STAT: avs_readdata <= {24'h000000, status};
					`FDT_OFS_DATA:     avs_readdata <= {24'h000000, dr_q};
					`FDT_OFS_CTRL:     avs_readdata <= {31'h00000000, dens_n_q};
					default:           avs_readdata <= 32'h00000000; // unmapped reads zero
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// engine, data register and status
	// ------------------------------------------------------------
	wire term_now = tick & force_pend_q & (state_q != ST_CRC); // see R14

	always @(posedge clk)
	begin
		if (!rstn)
		begin
			state_q      <= ST_IDLE;
			cnt_q        <= 14'h0000;
			miss_q       <= 2'd0;
			dr_q         <= 8'h00;
			dr_full_q    <= 1'b0;
			drq_q        <= 1'b0;
			busy_q       <= 1'b0;
			lost_q       <= 1'b0;
			type1_q      <= 1'b1;
			imm_q        <= 1'b0;
			idx_en_q     <= 1'b0;
			force_pend_q <= 1'b0;
			idx_seen_q   <= 1'b0;
			idx_prev_q   <= 1'b0;
			dens_n_q     <= `FDT_CTRL_RESET;
			crc_q        <= `FDT_CRC_PRESET;
			wr_gate      <= 1'b0;
			wr_strobe    <= 1'b0;
			wr_byte      <= 8'h00;
			wr_clk       <= 8'h00;
		end
		else if (ce)
		begin
			idx_prev_q <= index_pulse;
			wr_strobe  <= 1'b0;
			if (wr_ctrl)
				dens_n_q <= avs_writedata[`FDT_CTRL_DENS_BIT];
			// host side of the data register; a slot transfer below overrides the drq clear
			if (wr_dr)
			begin
				dr_q      <= avs_writedata[7:0];
				dr_full_q <= 1'b1;
			end
			if (wr_dr | rd_dr)
				drq_q <= 1'b0; // see R17
			if (state_q != ST_IDLE)
				cnt_q <= tick ? byte_cyc - 14'h0001 : cnt_q - 14'h0001;
			if (idx_rise && state_q != ST_IDLE)
				idx_seen_q <= 1'b1;
			// idle has nothing to do and falls to the default branch
			case (state_q)
				ST_WAIT:
				begin
					// waits for the leading index edge with a byte loaded
					if (tick)
					begin
						if (force_pend_q)
							state_q <= ST_IDLE;
						else if (dr_full_q && (idx_seen_q || idx_rise))
						begin
							state_q    <= ST_RUN;
							idx_seen_q <= 1'b0;
							cnt_q      <= 14'h0000;
						end
						else if (!dr_full_q)
						begin
							miss_q <= miss_q + 2'd1;
							if (miss_q == `FDT_START_SLOTS)
							begin
								state_q <= ST_IDLE;
								lost_q  <= 1'b1;
							end
						end
					end
				end
				ST_RUN:
				begin
					if (tick)
					begin
						if (term_now || idx_seen_q)
						begin
							state_q <= ST_IDLE;
							wr_gate <= 1'b0;
						end
						else
						begin
							wr_gate   <= 1'b1;
							wr_strobe <= 1'b1;
							dr_full_q <= wr_dr;
							drq_q     <= 1'b1; // see R17
							lost_q    <= lost_q | ~dr_full_q; // see R23
							if (enc_crc)
							begin
								wr_byte <= crc_q[15:8]; // see R4
								wr_clk  <= `FDT_CLK_ALL;
								state_q <= ST_CRC;
							end
							else
							begin
								wr_byte <= enc_byte;
								wr_clk  <= enc_clk;
								crc_q   <= crc_next;
							end
						end
					end
				end
				ST_CRC:
				begin
					// second crc byte is never cut short by a forced interrupt
					if (tick)
					begin
						wr_byte   <= crc_q[7:0];
						wr_clk    <= `FDT_CLK_ALL;
						wr_strobe <= 1'b1;
						state_q   <= ST_RUN;
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
			if (state_q != ST_IDLE && (term_now || (state_q == ST_WAIT && tick && force_pend_q)))
			begin
				busy_q       <= 1'b0; // see R8
				force_pend_q <= 1'b0;
			end
			else if (state_q == ST_RUN && tick && idx_seen_q)
				busy_q <= 1'b0;
			else if (state_q == ST_WAIT && tick && !dr_full_q && miss_q == `FDT_START_SLOTS)
				busy_q <= 1'b0;
			// command register writes
			if (new_cmd)
			begin
				state_q      <= ST_WAIT;
				busy_q       <= 1'b1; // see R15
				lost_q       <= 1'b0;
				type1_q      <= 1'b0;
				drq_q        <= 1'b1;
				miss_q       <= 2'd0;
				idx_seen_q   <= 1'b0;
				force_pend_q <= 1'b0;
				crc_q        <= `FDT_CRC_PRESET;
				cnt_q        <= byte_cyc - 14'h0001;
			end
			else if (force_cmd)
			begin
				idx_en_q <= cmd[`FDT_COND_INDEX]; // see R9
				imm_q    <= cmd[`FDT_COND_IMM] | (imm_q & (cmd[3:0] != 4'h0)); // see R12
				if (busy_q)
					force_pend_q <= 1'b1; // see R8, R11
				else
				begin
					busy_q  <= 1'b0; // see R16
					type1_q <= 1'b1;
					lost_q  <= 1'b0;
					drq_q   <= 1'b0;
				end
			end
		end
	end

	// interrupt request: sets win over clears
	wire done_irq = (state_q == ST_RUN && tick && idx_seen_q && !force_pend_q) ||
	                (state_q == ST_WAIT && tick && !dr_full_q && !force_pend_q && miss_q == `FDT_START_SLOTS);
	wire irq_set  = done_irq |
	                (force_cmd & cmd[`FDT_COND_IMM]) |       // see R12
	                (idx_rise & idx_en_q);                   // see R10
	wire irq_clr  = (rd_stat | wr_cmd) & ~imm_q;             // see R18

	always @(posedge clk)
	begin
		if (!rstn)
			interrupt_request_out_q <= 1'b0;
		else if (ce)
			interrupt_request_out_q <= irq_set | (interrupt_request_out_q & ~irq_clr); // see R10
	end

endmodule

/* verif/fdt_drive.sv */
// drive stand-in: the spinning disk gives one index pulse a turn
// assumes the encoder clock and its synchronous active-low reset
`timescale 1ns/100ps

module fdt_drive #(
	parameter integer IDX_PERIOD = 3000,
	parameter integer IDX_WIDTH  = 20
) (
	// clock and reset
	input  wire clk,
	input  wire rstn,
	// index sensor
	output reg  index_pulse
);
	// ----------------------------------------
	// rotation
	// ----------------------------------------
	reg [15:0] turn_q;

	// pulse sits at the end of a turn so reset reads see it low
	always @(posedge clk)
	begin
		if (!rstn || turn_q == IDX_PERIOD - 1)
			turn_q <= 16'h0;
		else
			turn_q <= turn_q + 16'h1;
		index_pulse <= rstn && turn_q >= IDX_PERIOD - IDX_WIDTH;
	end
endmodule

/* verif/fdt_track_encode_bench.sv */
// self-checking bench for the track encoder
// assumes the drive stand-in and the bound port checker
`timescale 1ns/100ps

module fdt_track_encode_bench;
	reg         clk;
	reg         rstn;
	reg  [3:0]  adr;
	reg         rd;
	reg         wr;
	reg  [31:0] wd;
	reg  [7:0]  rq;
	reg  [15:0] crc;
	integer     fails;
	integer     checks;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	wire        index_pulse;
	wire        density_select_n;
	wire        interrupt_request_out;
	wire        data_request_out;
	wire        wr_gate;
	wire        wr_strobe;
	wire [7:0]  wr_byte;
	wire [7:0]  wr_clk;
	wire [3:0]  ev;

	// events the bench waits on
	assign ev = {interrupt_request_out, !wr_gate, wr_strobe, data_request_out};

	// slots shortened so a track fits the run
	fdt_track_encode #(
		.BYTE_CYC_FM  (14'd16),
		.BYTE_CYC_MFM (14'd12)
	) fdt_track_encode_inst (
		.clk, .rstn, .ce(1'b1), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
		.index_pulse, .density_select_n, .interrupt_request_out, .data_request_out,
		.wr_gate, .wr_strobe, .wr_byte, .wr_clk
	);

	fdt_drive fdt_drive_inst (
		.clk,
		.rstn,
		.index_pulse
	);

	// 250 MHz
	always #2 clk = !clk;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	function [15:0] crc_step(input [15:0] c, input [7:0] d);
		integer i;
		begin
			crc_step = c;
			for (i = 7; i >= 0; i = i - 1)
				crc_step = {crc_step[14:0], 1'b0} ^ ((crc_step[15] ^ d[i]) ? 16'h1021 : 16'h0);
		end
	endfunction

	task test_done;
		begin
			$display("checks %0d fails %0d", checks, fails);
			if (fails == 0 && checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask

	task hang;
		begin
			fails = fails + 1;
			$display("mismatch wait expected 1 seen 0");
			test_done;
		end
	endtask

	task chk(input [8*6-1:0] nm, input [7:0] e, input [7:0] g);
		begin
			checks = checks + 1;
			if (g !== e)
			begin
				fails = fails + 1;
				$display("mismatch %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask

	// request held until waitrequest is seen low
	task bus(input [3:0] a, input w, input [7:0] d);
		integer n;
		begin
			@(posedge clk);
			adr <= a;
			wd <= {24'h0, d};
			rd <= !w;
			wr <= w;
			n = 0;
			#1;
			while (avs_waitrequest !== 1'b0)
			begin
				n = n + 1;
				if (n > 50)
					hang;
				@(posedge clk);
				#1;
			end
			@(posedge clk);
			rq = avs_readdata[7:0];
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask

	// bounded wait for an event bit to be high at the next edge or later
	task wt(input [1:0] s);
		integer n;
		begin
			n = 0;
			@(posedge clk);
			#1;
			while (ev[s] !== 1'b1)
			begin
				n = n + 1;
				if (n > 5000)
					hang;
				@(posedge clk);
				#1;
			end
		end
	endtask

	task gap(input integer n);
		repeat (n) @(posedge clk);
	endtask

	task irq(input e);
		chk("irq", {7'h0, e}, {7'h0, interrupt_request_out});
	endtask

	// one data request answered, then the byte on the wire checked
	task put(input [7:0] d, input [7:0] eb, input [7:0] ec, input pre);
		begin
			if (pre)
				crc = 16'hffff;
			crc = crc_step(crc, eb);
			wt(0);
			bus(4'h4, 1'b1, d);
			@(posedge clk);
			#1;
			chk("drq", 8'h00, {7'h0, data_request_out});
			wt(1);
			chk("byte", eb, wr_byte);
			chk("clk", ec, wr_clk);
		end
	endtask

	// a stop request between the crc bytes must not split them
	task crcs(input frc);
		reg [15:0] e;
		begin
			e = crc;
			put(8'hf7, e[15:8], 8'hff, 1'b0);
			if (frc)
				bus(4'h0, 1'b1, 8'hd0);
			wt(1);
			chk("crclo", e[7:0], wr_byte);
		end
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		adr = 4'h0;
		rd = 1'b0;
		wr = 1'b0;
		wd = 32'h0;
		crc = 16'hffff;
		fails = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		chk("dens", 8'h01, {7'h0, density_select_n});
		bus(4'h0, 1'b0, 8'h0);
		chk("stat", 8'h00, rq);
		bus(4'hc, 1'b0, 8'h0);
		chk("unmap", 8'h00, rq);
		$display("test reset done");
		// single density, all clock patterns
		bus(4'h8, 1'b1, 8'h01);
		bus(4'h0, 1'b1, 8'hf0);
		bus(4'h0, 1'b0, 8'h0);
		chk("stat", 8'h03, rq);
		repeat (11) put(8'hff, 8'hff, 8'hff, 1'b0);
		repeat (6) put(8'h00, 8'h00, 8'hff, 1'b0);
		put(8'hfe, 8'hfe, 8'hc7, 1'b1);
		put(8'h00, 8'h00, 8'hff, 1'b0);
		put(8'hf4, 8'hf4, 8'hff, 1'b0);
		put(8'hf8, 8'hf8, 8'hc7, 1'b1);
		put(8'hfb, 8'hfb, 8'hc7, 1'b1);
		put(8'hfc, 8'hfc, 8'hd7, 1'b0);
		put(8'hfd, 8'hfd, 8'hff, 1'b0);
		put(8'hff, 8'hff, 8'hff, 1'b0);
		crcs(1'b1);
		wt(2);
		irq(1'b0);
		bus(4'h0, 1'b0, 8'h0);
		chk("stat", 8'h00, rq & 8'h01);
		gap(8000);
		$display("test fm done");
		// double density marks, fill byte and stop while busy
		bus(4'h8, 1'b1, 8'h00);
		#1;
		chk("dens", 8'h00, {7'h0, density_select_n});
		bus(4'h0, 1'b1, 8'hf0);
		repeat (22) put(8'h4e, 8'h4e, 8'hff, 1'b0);
		repeat (12) put(8'h00, 8'h00, 8'hff, 1'b0);
		repeat (3) put(8'hf5, 8'ha1, 8'hef, 1'b1);
		put(8'hf6, 8'hc2, 8'hf7, 1'b0);
		put(8'hfc, 8'hfc, 8'hff, 1'b0);
		put(8'hfe, 8'hfe, 8'hff, 1'b0);
		put(8'hf9, 8'hf9, 8'hff, 1'b0);
		crcs(1'b0);
		wt(1);
		chk("fill", 8'h00, wr_byte);
		bus(4'h0, 1'b0, 8'h0);
		chk("stat", 8'h05, rq & 8'h05);
		bus(4'h0, 1'b1, 8'hd0);
		wt(2);
		bus(4'h0, 1'b0, 8'h0);
		chk("stat", 8'h04, rq & 8'h05);
		gap(8000);
		bus(4'h0, 1'b1, 8'hd0);
		gap(8000);
		bus(4'h0, 1'b0, 8'h0);
		chk("stat", 8'h00, rq & 8'h05);
		$display("test mfm done");
		// index condition, low bits ignored
		bus(4'h0, 1'b1, 8'hd7);
		irq(1'b0);
		wt(3);
		bus(4'h0, 1'b0, 8'h0);
		@(posedge clk);
		#1;
		irq(1'b0);
		gap(8000);
		bus(4'h0, 1'b1, 8'hd0);
		gap(8000);
		// immediate interrupt survives reads until d0
		bus(4'h0, 1'b1, 8'hd8);
		@(posedge clk);
		#1;
		irq(1'b1);
		bus(4'h0, 1'b0, 8'h0);
		gap(8000);
		irq(1'b1);
		bus(4'h0, 1'b1, 8'hd0);
		@(posedge clk);
		#1;
		irq(1'b1);
		bus(4'h0, 1'b0, 8'h0);
		@(posedge clk);
		#1;
		irq(1'b0);
		$display("test irq done");
		test_done;
	end
endmodule

/* verif/fdt_track_encode_props.sv */
// port checker for the track encoder
// assumes ce held high and a single bus master
`timescale 1ns/100ps

module fdt_props #(
	parameter [13:0] BYTE_CYC_FM  = 14'd8000,
	parameter [13:0] BYTE_CYC_MFM = 14'd4000
) (
	// clock and reset
	input wire        clk,
	input wire        rstn,
	// register bus
	input wire [3:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	// drive and host pins
	input wire        index_pulse,
	input wire        density_select_n,
	input wire        interrupt_request_out,
	input wire        data_request_out,
	input wire        wr_gate,
	input wire        wr_strobe,
	input wire [7:0]  wr_byte,
	input wire [7:0]  wr_clk
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// a stop may wait out a crc pair plus one slot
	localparam integer FRC_LIM = 3 * BYTE_CYC_FM + 8;
	wire       cmd_w = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
	wire       st_r  = avs_read && !avs_waitrequest && avs_address == 4'h0;
	wire [7:0] cv    = avs_writedata[7:0];
	reg        imm_q;
	reg        frc_q;
	reg [15:0] fcnt_q;

	// d8 latch and pending forced stop
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			imm_q  <= 1'b0;
			frc_q  <= 1'b0;
			fcnt_q <= 16'h0;
		end
		else
		begin
			if (cmd_w && cv[7:4] == 4'hd)
				imm_q <= cv[3] || (imm_q && cv != 8'hd0);
			if (cmd_w && cv[7:4] == 4'hd)
				frc_q <= wr_gate;
			else if (!wr_gate)
				frc_q <= 1'b0;
			fcnt_q <= frc_q ? fcnt_q + 16'h1 : 16'h0;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest longer than one cycle");
	a_drq_clear: assert property ((avs_read || avs_write) && !avs_waitrequest && avs_address == 4'h4
		|=> !data_request_out || wr_strobe) else $error("data request kept after data access");
	a_read_width: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_imm_raise: assert property (cmd_w && cv[7:4] == 4'hd && cv[3] |-> ##[1:2] interrupt_request_out)
		else $error("immediate interrupt late");
	a_imm_hold: assert property (imm_q && interrupt_request_out |=> interrupt_request_out)
		else $error("latched interrupt dropped");
	a_read_clear: assert property (st_r && !imm_q && !index_pulse |=> !interrupt_request_out)
		else $error("status read left interrupt");
	a_zero_quiet: assert property (cmd_w && cv == 8'hd0 && !imm_q && !interrupt_request_out
		|=> !interrupt_request_out [*3]) else $error("d0 raised interrupt");
	a_a1_mark: assert property (wr_strobe && wr_clk == 8'hef |-> wr_byte == 8'ha1 && !density_select_n)
		else $error("bad a1 mark");
	a_c2_mark: assert property (wr_strobe && wr_clk == 8'hf7 |-> wr_byte == 8'hc2 && !density_select_n)
		else $error("bad c2 mark");
	a_fm_clock: assert property (wr_strobe && (wr_clk == 8'hc7 || wr_clk == 8'hd7)
		|-> density_select_n && wr_byte >= 8'hf8) else $error("bad fm mark clock");
	a_force_stop: assert property (fcnt_q <= FRC_LIM)
		else $error("forced stop too slow");

	c_imm: cover property (cmd_w && cv == 8'hd8);
	c_a1: cover property (wr_strobe && wr_clk == 8'hef);
	c_lost: cover property (st_r && avs_readdata[2]);
endmodule

bind fdt_track_encode fdt_props #(
	.BYTE_CYC_FM  (BYTE_CYC_FM),
	.BYTE_CYC_MFM (BYTE_CYC_MFM)
) fdt_props_inst (
	.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest, .index_pulse, .density_select_n,
	.interrupt_request_out, .data_request_out, .wr_gate, .wr_strobe, .wr_byte, .wr_clk
);
